// >>> verilog/anr_adv_regs.sv
// advertisement registers and base page codeword assembly
// assumes a decoded management register port on clk; partner nonce and
// negotiation control come from same-clock logic
`timescale 1ns/1ps
`default_nettype none
`include "anr_consts.svh"
module anr_adv_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] mgmt_dev,
    input wire logic [15:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire logic neg_start,
    input wire logic page_done,
    input wire logic nonce_exchanged,
    input wire logic [4:0] partner_nonce,
    output anr_pkg::anr_codeword_type base_page,
    output logic page_active
);
    import anr_pkg::*;

    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_sync_n;
    anr_word_type adv_low_q;
    anr_word_type adv_mid_q;
    anr_state_type state_q;
    logic [4:0] hw_nonce;
    logic dev_hit;
    logic [4:0] echo_tx;
    anr_codeword_type page_d;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_sync_n = rst_s2_q;

    anr_nonce_gen u_nonce (
        .clk(clk),
        .rst_sync_n(rst_sync_n),
        .nonce(hw_nonce)
    );

    assign dev_hit = (mgmt_dev == `ANR_DEV_ADDR);

    // writable fields; acknowledge bit never stored
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            adv_low_q <= `ANR_ADV_LOW_RESET;
            adv_mid_q <= `ANR_ADV_MID_RESET;
        end else if (mgmt_wr && dev_hit) begin
            if (mgmt_addr == `ANR_ADV_LOW_ADDR) begin
                adv_low_q <= mgmt_wdata & `ANR_LOW_WRITE_MASK;
            end
            if (mgmt_addr == `ANR_ADV_MID_ADDR) begin
                adv_mid_q <= mgmt_wdata;
            end
        end
    end

    // read port returns stored values, not transmitted nonces
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mgmt_rdata <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_rd;
            if (mgmt_rd && dev_hit && mgmt_addr == `ANR_PRESENCE_ADDR) begin
                mgmt_rdata <= `ANR_PRESENCE_VALUE;
            end else if (mgmt_rd && dev_hit && mgmt_addr == `ANR_ADV_LOW_ADDR) begin
                mgmt_rdata <= adv_low_q;
            end else if (mgmt_rd && dev_hit && mgmt_addr == `ANR_ADV_MID_ADDR) begin
                mgmt_rdata <= adv_mid_q;
            end else if (mgmt_rd) begin
                mgmt_rdata <= 16'h0000;
            end
        end
    end

    // echo switches to partner nonce after exchange
    assign echo_tx = nonce_exchanged ? partner_nonce : adv_low_q[9:5];

    // codeword bits 47:32 belong to other logic and stay zero here
    assign page_d = {16'h0000,
                     adv_mid_q[15:5],
                     hw_nonce,
                     adv_low_q[15],
                     1'b0,
                     adv_low_q[13],
                     adv_low_q[12:10],
                     echo_tx,
                     adv_low_q[4:0]};

    // capture on start or restart, hold until page done without a restart; echo field takes partner nonce on exchange
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= ANR_IDLE;
            base_page <= 48'h000000000000;
            page_active <= 1'b0;
        end else begin
            case (state_q)
                ANR_IDLE: begin
                    if (neg_start) begin
                        base_page <= page_d;
                        state_q <= ANR_HOLD;
                        page_active <= 1'b1;
                    end
                end
                ANR_HOLD: begin
                    if (neg_start) begin
                        base_page <= page_d;
                    end else if (nonce_exchanged) begin
                        base_page[9:5] <= partner_nonce;
                    end
                    if (page_done && !neg_start) begin
                        state_q <= ANR_IDLE;
                        page_active <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ANR_IDLE;
                    page_active <= 1'b0;
                end
            endcase
        end
    end
endmodule // anr_adv_regs
`default_nettype wire

// >>> verilog/anr_consts.svh
// constants for the auto-negotiation advertisement register block
// assumes a management (mdio-style) register port and one 250 MHz clock
`ifndef ANR_CONSTS_SVH
`define ANR_CONSTS_SVH

`define ANR_DEV_ADDR 5'h07
`define ANR_PRESENCE_ADDR 16'h0005
`define ANR_ADV_LOW_ADDR 16'h0010
`define ANR_ADV_MID_ADDR 16'h0011
`define ANR_ADV_LOW_RESET 16'h1001
`define ANR_ADV_MID_RESET 16'h0080
`define ANR_PRESENCE_VALUE 16'h0080
`define ANR_LOW_WRITE_MASK 16'hBFFF
`define ANR_LFSR_SEED 16'hACE1
`define ANR_NP_BIT 15
`define ANR_ECHO_LSB 5
`define ANR_NONCE_W 5

`endif

// >>> verilog/anr_pkg.sv
// types for the auto-negotiation advertisement register block
// assumes anr_consts.svh is compiled alongside
package anr_pkg;
    typedef logic [15:0] anr_word_type;
    typedef logic [47:0] anr_codeword_type;
    typedef logic [4:0] anr_nonce_type;
    typedef enum logic [1:0] {
        ANR_IDLE = 2'b01,
        ANR_HOLD = 2'b10
    } anr_state_type;
endpackage

// >>> verilog/anr_nonce_gen.sv
// random nonce source for the outgoing base page
// assumes the same clock and synchronised reset as the register block
`timescale 1ns/1ps
`default_nettype none
`include "anr_consts.svh"
module anr_nonce_gen (
    input wire logic clk,
    input wire logic rst_sync_n,
    output logic [4:0] nonce
);
    import anr_pkg::*;
    logic [15:0] lfsr_q;

    // free-running lfsr as random source
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lfsr_q <= `ANR_LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    assign nonce = lfsr_q[4:0];
endmodule // anr_nonce_gen
`default_nettype wire

// >>> verification/anr_props.sv
// checker for the advertisement registers
// bound to anr_adv_regs; one clock, async reset
`timescale 1ns/1ps
`default_nettype none
module anr_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mgmt_rd,
    input wire logic mgmt_rvalid,
    input wire logic neg_start,
    input wire logic page_done,
    input wire logic nonce_exchanged,
    input wire logic [4:0] partner_nonce,
    input wire anr_pkg::anr_codeword_type base_page,
    input wire logic page_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_read_answer:
    assert property (mgmt_rd |=> mgmt_rvalid) else $error("no answer");
    chk_answer_cause:
    assert property (mgmt_rvalid |-> $past(mgmt_rd)) else $error("stray rvalid");
    chk_ack_zero:
    assert property (!base_page[14]) else $error("ack set");
    chk_upper_zero:
    assert property (base_page[47:32] == 16'h0000) else $error("upper set");
    chk_start_holds:
    assert property (neg_start |=> page_active) else $error("no hold");
    chk_done_frees:
    assert property (page_done && !neg_start |=> !page_active) else $error("stuck");
    chk_word_stable:
    assert property (!$past(neg_start) |-> $stable({base_page[31:21], base_page[15:10]}))
        else $error("word moved");
    chk_echo_follows:
    assert property (page_active && nonce_exchanged && $past(nonce_exchanged)
        && $stable(partner_nonce) |-> base_page[9:5] == partner_nonce) else $error("echo");
    cover property (mgmt_rvalid);
    cover property ($rose(page_active));
    cover property (page_active && nonce_exchanged);
endmodule // anr_props
bind anr_adv_regs anr_props u (.clk, .rst_n, .mgmt_rd, .mgmt_rvalid, .neg_start, .page_done,
    .nonce_exchanged, .partner_nonce, .base_page, .page_active);
`default_nettype wire

// >>> verification/anr_partner_model.sv
// far-end negotiation model
// drives on falling edges of the bench clock
`timescale 1ns/1ps
`default_nettype none
module anr_partner_model (
    input wire logic clk,
    output logic neg_start,
    output logic page_done,
    output logic nonce_exchanged,
    output logic [4:0] partner_nonce
);
    initial {neg_start, page_done, nonce_exchanged, partner_nonce} = 8'h00;
    // start, hold, finish
    task automatic exchange(input int hold, input logic x, input logic [4:0] pn);
        @(negedge clk) neg_start = 1'h1;
        @(negedge clk) {neg_start, nonce_exchanged, partner_nonce} = {1'h0, x, pn};
        repeat (hold) @(negedge clk);
        page_done = 1'h1;
        @(negedge clk) {page_done, nonce_exchanged, partner_nonce} = {2'h0, ~pn};
    endtask
endmodule // anr_partner_model
`default_nettype wire

// >>> verification/tb_autoneg_base_page_advert_regs.sv
// bench for the advertisement registers
// uses anr_adv_regs, its checker and the partner model
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_base_page_advert_regs;
    import anr_pkg::*;
    logic clk, rst_n, mgmt_wr, mgmt_rd, mgmt_rvalid, neg_start, page_done, nonce_exchanged;
    logic page_active, act_q;
    logic [4:0] mgmt_dev, partner_nonce;
    logic [15:0] mgmt_addr, mgmt_wdata, mgmt_rdata, w, m;
    anr_codeword_type base_page;
    logic [42:0] seen;
    int errors, checked;
    logic [15:0] rq[$];
    logic [42:0] pq[$];
    assign seen = {base_page[47:21], base_page[15:0]};
    anr_adv_regs dut (.clk, .rst_n, .mgmt_dev, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata,
        .mgmt_rdata, .mgmt_rvalid, .neg_start, .page_done, .nonce_exchanged, .partner_nonce,
        .base_page, .page_active);
    anr_partner_model far (.clk, .neg_start, .page_done, .nonce_exchanged, .partner_nonce);
    task automatic chk(input string n, input logic [47:0] s, e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic report_and_stop;
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bus(input logic wr, rd, input logic [15:0] a, d, input logic [4:0] v = 5'h07);
        @(negedge clk) {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata, mgmt_dev} = {wr, rd, a, d, v};
        if (rd) rq.push_back(d);
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        act_q <= page_active;
        if (mgmt_rvalid) chk("rdata", mgmt_rdata, rq.pop_front());
        if (page_active && !act_q) chk("page", seen, pq.pop_front());
    end
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        errors++;
        report_and_stop();
    end
    initial begin
        {rst_n, mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata, mgmt_dev} = {35'h0, 5'h07};
        void'($urandom(74));
        repeat (10) @(negedge clk);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
        bus(0, 1, 16'h0010, 16'h1001);
        bus(0, 1, 16'h0011, 16'h0080);
        bus(0, 1, 16'h0020, 16'h0000);
        bus(1, 0, 16'h0005, 16'hFFFF);
        bus(1, 0, 16'h0010, 16'hFFFF);
        bus(1, 0, 16'h0010, 16'h0000, 5'h03);
        bus(0, 1, 16'h0005, 16'h0080);
        bus(0, 1, 16'h0010, 16'hBFFF);
        for (int i = 0; i < 4; i++) begin
            w = 16'($urandom);
            m = 16'($urandom) & 16'hFFBF;
            bus(1, 0, 16'h0010, w);
            bus(1, 0, 16'h0011, m);
            bus(0, 1, 16'h0011, m);
            bus(0, 0, 16'h0000, 16'h0000);
            pq.push_back({16'h0000, m[15:5], w[15], 1'h0, w[13:0]});
            fork
                far.exchange(i * 3 + 2, i[0], 5'($urandom));
                bus(1, 0, 16'h0010, ~w);
            join
            bus(0, 1, 16'h0010, ~w & 16'hBFFF);
        end
        bus(0, 0, 16'h0000, 16'h0000);
        repeat (4) @(negedge clk);
        report_and_stop();
    end
endmodule // tb_autoneg_base_page_advert_regs
`default_nettype wire
